// ### src/rsc_top.v
// Remote schedule select, stop/inhibit gating and status relays
//
// The address map and the plain strobed port were left to the implementer.
`include "rsc_defs.vh"
`timescale 1ns/10ps
`default_nettype none
module rsc_top #(
    parameter DEB_CYC = `RSC_DEB_CYC
) (
    input  wire       ref_clk,
    input  wire       nrst,
    input  wire [6:0] sel_n,
    input  wire       estop_n,
    input  wire       inhibit_n,
    input  wire       start_req,
    input  wire       ev_init,
    input  wire       ev_portion,
    input  wire       ev_fsopen,
    input  wire       ev_wait,
    input  wire       weld_mark,
    input  wire       alarm,
    input  wire [3:0] addr,
    input  wire [7:0] wdata,
    input  wire       wr,
    input  wire       rd,
    output reg  [7:0] rdata,
    output reg  [6:0] sched_q,
    output wire       start_ok,
    output wire       abort,
    output reg        ac_status_relay,
    output reg        dc_status_relay,
    output reg        air_valve1,
    output reg        air_valve2
);
    reg  [1:0] rst_sync_q;
    wire       rst_n;
    wire [8:0] pin_n;
    wire [8:0] lvl;
    reg  [8:0] lvl_d1_q;
    reg  [7:0] ctrl_q;
    reg  [7:0] relay_q;
    reg  [6:0] pwrup_q;
    reg  [23:0] settle_q;
    reg        pwrup_done_q;
    wire       pwrup_take;
    reg  [6:0] sched_d;
    reg        weld_act_d;
    wire       r1_head2;
    reg        weld_act_q;
    wire       chain_on;
    wire       manual;
    wire       dual_air;
    wire       step_dn;
    wire       step_up;
    wire       sreset;
    wire       stop;
    wire       inh;
    wire [2:0] r1_sel;
    wire [2:0] r2_sel;
    wire [6:0] bin_sel;
    genvar     g;

    // Counters are 24 bits wide; longer spans are cut to fit
    localparam [31:0] DEB_FULL    = DEB_CYC;
    localparam [23:0] DEB_HOLD    = DEB_FULL[23:0];
    localparam [31:0] SETTLE_FULL = DEB_CYC + `RSC_SETTLE_PAD;
    localparam [23:0] SETTLE_CYC  = SETTLE_FULL[23:0];

    // Reset enters asynchronously but is released on a clock edge
    always @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            rst_sync_q <= 2'b00;
        end else begin
            rst_sync_q <= {rst_sync_q[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_q[1];

    // Nine contact pins, each through its own debouncer
    assign pin_n = {inhibit_n, estop_n, sel_n};
    generate
        for (g = 0; g < `RSC_NIN; g = g + 1) begin : deb
            rsc_debounce #(
                .CNT_W (24),
                .HOLD  (DEB_HOLD)
            ) u_deb (
                .clk     (ref_clk),
                .rst_n   (rst_n),
                .pin_n   (pin_n[g]),
                .level_q (lvl[g])
            );
        end
    endgenerate

    // Delayed levels give one-cycle leading-edge pulses
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            lvl_d1_q <= 9'h000;
        end else begin
            lvl_d1_q <= lvl;
        end
    end

    // Select lines weights 1..64
    assign bin_sel  = lvl[6:0];
    assign manual   = ~lvl[3];
    assign chain_on = ctrl_q[0] | manual;
    assign dual_air = ctrl_q[1];
    assign step_dn  = lvl[0] & ~lvl_d1_q[0];
    assign step_up  = lvl[1] & ~lvl_d1_q[1];
    assign sreset   = lvl[2] & ~lvl_d1_q[2];
    assign stop     = lvl[7];
    assign inh      = lvl[8];

    // Debounced levels are only true after the debounce span, so the
    // power-up schedule is taken once that span and a margin have passed
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            settle_q     <= 24'h000000;
            pwrup_done_q <= 1'b0;
        end else if (!pwrup_done_q) begin
            if (settle_q >= SETTLE_CYC) begin
                pwrup_done_q <= 1'b1;
            end else begin
                settle_q <= settle_q + 24'h000001;
            end
        end
    end

    assign pwrup_take = ~pwrup_done_q & (settle_q >= SETTLE_CYC);

    // Saturating step, shared by the up and down paths
    function [6:0] sched_step;
        input [6:0] cur;
        input       up;
        begin
            if (up) begin
                sched_step = (cur == `RSC_SCHED_MAX) ? cur : cur + 7'h01;
            end else begin
                sched_step = (cur == `RSC_SCHED_MIN) ? cur : cur - 7'h01;
            end
        end
    endfunction

    // Up and down together cancel; reset outranks both
    always @* begin
        sched_d = sched_q;
        if (!chain_on) begin
            sched_d = bin_sel;
        end else if (sreset) begin
            sched_d = pwrup_q;
        end else if (step_up && !step_dn) begin
            sched_d = sched_step(sched_q, 1'b1);
        end else if (step_dn && !step_up) begin
            sched_d = sched_step(sched_q, 1'b0);
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            pwrup_q <= `RSC_SCHED_MIN;
            sched_q <= `RSC_SCHED_MIN;
        end else begin
            if (pwrup_take) begin
                pwrup_q <= bin_sel;
            end
            // Software write lands last so it wins over the capture
            if (wr && addr == `RSC_ADDR_PWRUP) begin
                pwrup_q <= wdata[6:0];
            end
            sched_q <= sched_d;
        end
    end

    // Start refused while stopped or inhibited
    assign start_ok = start_req & ~stop & ~inh;
    assign abort    = stop;

    // Stop outranks a start; a start outranks the end event
    always @* begin
        weld_act_d = weld_act_q;
        if (stop) begin
            weld_act_d = 1'b0;
        end else if (start_ok) begin
            weld_act_d = 1'b1;
        end else if (ev_portion) begin
            weld_act_d = 1'b0;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            weld_act_q <= 1'b0;
        end else begin
            weld_act_q <= weld_act_d;
        end
    end

    // Registers: control, relay setup, status, power-up schedule
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= `RSC_CTRL_RST;
        end else if (wr && addr == `RSC_ADDR_CTRL) begin
            ctrl_q <= {6'h00, wdata[1:0]};
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            relay_q <= `RSC_RELAY_RST;
        end else if (wr && addr == `RSC_ADDR_RELAY) begin
            relay_q <= {2'b00, wdata[5:0]};
        end
    end

    // Read data stand one cycle after the strobe, zero otherwise
    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            rdata <= 8'h00;
        end else if (rd) begin
            case (addr)
                `RSC_ADDR_CTRL:   rdata <= ctrl_q;
                `RSC_ADDR_RELAY:  rdata <= relay_q;
                `RSC_ADDR_STATUS: rdata <= {weld_act_q, sched_q};
                `RSC_ADDR_PWRUP:  rdata <= {1'b0, pwrup_q};
                default:          rdata <= 8'h00;
            endcase
        end else begin
            rdata <= 8'h00;
        end
    end

    function is_head2;
        input [2:0] s;
        begin
            is_head2 = (s == `RSC_EV_HEAD2);
        end
    endfunction

    // In two-head mode any other first-relay code acts as unused
    assign r1_sel = (dual_air && !is_head2(relay_q[2:0])) ?
                    `RSC_EV_UNUSED : relay_q[2:0];
    assign r2_sel = relay_q[5:3];
    assign r1_head2 = dual_air & is_head2(r1_sel);

    // Relay codes above the four events close nothing

    function relay_ev;
        input [2:0] s;
        begin
            case (s)
                `RSC_EV_INIT:    relay_ev = ev_init;
                `RSC_EV_PORTION: relay_ev = ev_portion;
                `RSC_EV_FSOPEN:  relay_ev = ev_fsopen;
                `RSC_EV_WAIT:    relay_ev = ev_wait;
                default:         relay_ev = 1'b0;
            endcase
        end
    endfunction

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            ac_status_relay <= 1'b0;
        end else begin
            // Second valve claims the relay: no events pass
            ac_status_relay <= is_head2(r1_sel) ? 1'b0 :
                               relay_ev(r1_sel);
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            dc_status_relay <= 1'b0;
        end else begin
            dc_status_relay <= relay_ev(r2_sel);
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            air_valve2 <= 1'b0;
        end else begin
            air_valve2 <= weld_act_q & r1_head2;
        end
    end

    always @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            air_valve1 <= 1'b0;
        end else begin
            air_valve1 <= weld_act_q & ~r1_head2;
        end
    end
endmodule
`default_nettype wire

// ### src/rsc_defs.vh
// Constants for the remote schedule control block
`ifndef RSC_DEFS_VH
`define RSC_DEFS_VH
`define RSC_SCHED_W      7
`define RSC_SCHED_MAX    7'h7f
`define RSC_SCHED_MIN    7'h00
`define RSC_DEB_MS       5
`define RSC_CLK_KHZ      25000
`define RSC_DEB_CYC      (`RSC_DEB_MS * `RSC_CLK_KHZ)
`define RSC_SETTLE_PAD   8
`define RSC_NIN          9
`define RSC_EV_INIT      3'h0
`define RSC_EV_PORTION   3'h1
`define RSC_EV_FSOPEN    3'h2
`define RSC_EV_WAIT      3'h3
`define RSC_EV_UNUSED    3'h4
`define RSC_EV_HEAD2     3'h5
`define RSC_ADDR_CTRL    4'h0
`define RSC_ADDR_RELAY   4'h1
`define RSC_ADDR_STATUS  4'h2
`define RSC_ADDR_PWRUP   4'h3
`define RSC_CTRL_RST     8'h00
`define RSC_RELAY_RST    8'h34
`endif

// ### src/rsc_debounce.v
// Synchroniser and debouncer for one contact input
`timescale 1ns/10ps
`default_nettype none
module rsc_debounce #(
    parameter CNT_W = 17,
    parameter [CNT_W-1:0] HOLD = 17'h1e848
) (
    input  wire clk,
    input  wire rst_n,
    input  wire pin_n,
    output reg  level_q
);
    reg             s1_q;
    reg             s2_q;
    reg [CNT_W-1:0] cnt_q;

    // Contacts pull the pin low when closed
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            s1_q    <= 1'b1;
            s2_q    <= 1'b1;
            cnt_q   <= {CNT_W{1'b0}};
            level_q <= 1'b0;
        end else begin
            s1_q <= pin_n;
            s2_q <= s1_q;
            if ((~s2_q) == level_q) begin
                cnt_q <= {CNT_W{1'b0}};
            end else if (cnt_q >= HOLD - 1'b1) begin
                cnt_q   <= {CNT_W{1'b0}};
                level_q <= ~s2_q;
            end else begin
                cnt_q <= cnt_q + 1'b1;
            end
        end
    end
endmodule
`default_nettype wire

// ### dv/rsc_contacts.sv
// Contact-closure model of the remote controller or chain box
`timescale 1ns/10ps
`default_nettype none
module rsc_contacts (
    input  wire logic [6:0] sel_c,
    input  wire logic       estop_c,
    input  wire logic       inh_c,
    output wire logic [6:0] sel_n,
    output wire logic       estop_n,
    output wire logic       inhibit_n
);
    // Closure pulls the pin low and lasts as long as commanded
    assign sel_n = ~sel_c;
    assign estop_n = ~estop_c;
    assign inhibit_n = ~inh_c;
endmodule
`default_nettype wire

// ### dv/rsc_top_chk.sv
// Port checker for the remote schedule block
`timescale 1ns/10ps
`default_nettype none
module rsc_top_chk (
    input wire logic       ref_clk,
    input wire logic       nrst,
    input wire logic [3:0] addr,
    input wire logic       rd,
    input wire logic [7:0] rdata,
    input wire logic [6:0] sched_q,
    input wire logic       start_req,
    input wire logic       start_ok,
    input wire logic       abort,
    input wire logic       air_valve1,
    input wire logic       air_valve2
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    chk_stop_blocks: assert property (abort |-> !start_ok)
        else $error("start during stop");
    chk_start_cause: assert property (start_ok |-> start_req)
        else $error("start without request");
    chk_read_idle: assert property (!$past(rd) |-> rdata == 8'h00)
        else $error("read data outside slot");
    chk_sched_read: assert property ($past(rd) && $past(addr) == 4'h2
        |-> rdata[6:0] == $past(sched_q)) else $error("status read");
    chk_unmapped_read: assert property ($past(rd) && $past(addr) > 4'h3
        |-> rdata == 8'h00) else $error("unmapped read");
    chk_reset_clear: assert property ($rose(nrst)
        |-> sched_q == 7'h00 && !air_valve1 && !air_valve2)
        else $error("outputs not clear");
    chk_stop_valves: assert property (abort [*3]
        |-> !air_valve1 && !air_valve2) else $error("valve in stop");
    chk_valve_cause: assert property ($rose(air_valve1 || air_valve2)
        |-> $past(start_ok) || $past(start_ok, 2)) else $error("valve");
    cover property (abort);
    cover property (air_valve2);
    cover property ($past(rd) && $past(addr) == 4'h2);
endmodule
bind rsc_top rsc_top_chk chk_u (.ref_clk(ref_clk), .nrst(nrst), .addr(addr),
    .rd(rd), .rdata(rdata), .sched_q(sched_q), .start_req(start_req),
    .start_ok(start_ok), .abort(abort), .air_valve1(air_valve1),
    .air_valve2(air_valve2));
`default_nettype wire

// ### dv/remote_schedule_control_io_tb.sv
// Bench for the remote schedule block
`timescale 1ns/10ps
`default_nettype none
module remote_schedule_control_io_tb;
    logic       ref_clk = 0, nrst = 0, estop_c = 0, inh_c = 0;
    logic       start_req = 0, alarm = 0, wr = 0, rd = 0;
    logic [6:0] sel_c = 0;
    logic [3:0] ev = 0, addr = 0;
    logic [7:0] wdata = 0;
    wire  [7:0] rdata;
    wire  [6:0] sel_n, sched_q;
    wire        estop_n, inhibit_n, start_ok, abort, ac, dc, v1, v2;
    int         bad_count = 0, checks_done = 0;
    logic [6:0] pat [4] = '{7'h7f, 7'h08, 7'h2d, 7'h48};
    always #20 ref_clk = ~ref_clk;
    rsc_contacts pm_u (.sel_c(sel_c), .estop_c(estop_c), .inh_c(inh_c),
        .sel_n(sel_n), .estop_n(estop_n), .inhibit_n(inhibit_n));
    // Short debounce keeps each closure near a dozen cycles
    rsc_top #(.DEB_CYC(4)) dut_u (.ref_clk(ref_clk), .nrst(nrst),
        .sel_n(sel_n), .estop_n(estop_n), .inhibit_n(inhibit_n),
        .start_req(start_req), .ev_init(ev[0]), .ev_portion(ev[1]),
        .ev_fsopen(ev[2]), .ev_wait(ev[3]), .weld_mark(alarm),
        .alarm(alarm), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .sched_q(sched_q), .start_ok(start_ok),
        .abort(abort), .ac_status_relay(ac), .dc_status_relay(dc),
        .air_valve1(v1), .air_valve2(v2));
    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        checks_done++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic reg_wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk) {addr, wdata, wr} <= {a, d, 1'b1};
        @(posedge ref_clk) wr <= 0;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e);
        @(posedge ref_clk) {addr, rd} <= {a, 1'b1};
        @(posedge ref_clk) rd <= 0;
        #1 chk(rdata, e);
    endtask
    task automatic wt(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    // Twelve cycles cover two sync stages, debounce and the update edge
    task automatic pin(input logic [6:0] s);
        @(posedge ref_clk) sel_c <= s;
        wt(12);
    endtask
    task automatic pulse(input logic [6:0] s, input logic [6:0] e);
        pin(s);
        pin(7'h00);
        chk({1'b0, sched_q}, {1'b0, e});
    endtask
    task automatic conclude;
        $display("checks %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    initial begin
        wt(4000);
        bad_count++;
        conclude;
    end
    initial begin
        wt(16);
        nrst <= 1;
        wt(3);
        rd_chk(4'h1, 8'h34);
        rd_chk(4'h3, 8'h00);
        reg_wr(4'h9, 8'hff);
        rd_chk(4'h9, 8'h00);
        foreach (pat[i]) begin
            pin(pat[i]);
            chk({1'b0, sched_q}, {1'b0, pat[i]});
        end
        rd_chk(4'h2, 8'h48);
        reg_wr(4'h3, 8'h05);
        reg_wr(4'h0, 8'h01);
        pin(7'h08);
        pin(7'h00);
        chk({1'b0, sched_q}, 8'h48);
        reg_wr(4'h0, 8'h00);
        pulse(7'h04, 7'h05);
        pulse(7'h02, 7'h06);
        pulse(7'h01, 7'h05);
        reg_wr(4'h3, 8'h7f);
        pulse(7'h04, 7'h7f);
        pulse(7'h02, 7'h7f);
        reg_wr(4'h3, 8'h00);
        pulse(7'h04, 7'h00);
        pulse(7'h01, 7'h00);
        for (int k = 0; k < 4; k++) begin
            reg_wr(4'h1, {2'b00, k[2:0], k[2:0]});
            @(posedge ref_clk) ev <= 4'h1 << k;
            wt(3);
            chk({6'h00, ac, dc}, 8'h03);
            @(posedge ref_clk) ev <= 4'h0;
            wt(3);
            chk({6'h00, ac, dc}, 8'h00);
        end
        @(posedge ref_clk) alarm <= 1;
        reg_wr(4'h0, 8'h02);
        for (int k = 0; k < 2; k++) begin
            reg_wr(4'h1, k ? 8'h24 : 8'h25);
            @(posedge ref_clk) start_req <= 1;
            @(posedge ref_clk) start_req <= 0;
            wt(3);
            chk({5'h00, ac, v1, v2}, k ? 8'h02 : 8'h01);
            @(posedge ref_clk) ev <= 4'h2;
            @(posedge ref_clk) ev <= 4'h0;
            wt(3);
            chk({5'h00, ac, v1, v2}, 8'h00);
        end
        @(posedge ref_clk) {start_req, estop_c} <= 2'b11;
        wt(12);
        chk({5'h00, abort, start_ok, v1}, 8'h04);
        @(posedge ref_clk) {estop_c, inh_c} <= 2'b01;
        wt(12);
        chk({6'h00, abort, start_ok}, 8'h00);
        @(posedge ref_clk) inh_c <= 0;
        wt(12);
        chk({6'h00, abort, start_ok}, 8'h01);
        conclude;
    end
endmodule
`default_nettype wire
